// ===== design/fsl_consts.svh
// Offsets, field positions, reset values and codes of the security block.
`ifndef FSL_CONSTS_SVH
`define FSL_CONSTS_SVH
// APB register byte offsets.
`define FSL_OFS_DIVIDER      12'h_000
`define FSL_OFS_STATUS       12'h_004
`define FSL_OFS_KEY          12'h_008
// Divider register fields.
`define FSL_DIV_PRESCALE_BIT 6
`define FSL_DIV_RESET        7'h_00
// Status register bit positions.
`define FSL_ST_SECURED       0
`define FSL_ST_EXT_BOOT      1
`define FSL_ST_ERASING       2
`define FSL_ST_ERASE_DONE    3
`define FSL_ST_KEY_OPEN      4
`define FSL_ST_RECOV_SEL     5
// Security word that leaves the part open; any other value secures it.
`define FSL_UNSECURE_CODE    16'h_E70A
// Boot fetch addresses.
`define FSL_BOOT_FLASH_ADDR  21'h02_0000
`define FSL_EXT_BOOT_ADDR    21'h00_0000
// Test instruction codes.
`define FSL_IR_SAMPLE        4'h_1
`define FSL_IR_IDCODE        4'h_2
`define FSL_IR_RECOVERY      4'h_8
`define FSL_IR_BYPASS        4'h_F
`define FSL_IR_CAPTURE       4'h_1
// Identification value; arbitrary.
`define FSL_IDCODE           32'h_1234_5001
`endif

// ===== design/fsl_pkg.sv
// Types of the flash security and lockout recovery block.
package fsl_pkg;
   // Test controller states, gray coded from Run-Test/Idle to Exit1-DR and from Select-IR to Update-IR.
   typedef enum logic [3:0] {
      TAP_RESET  = 4'h_0, TAP_IDLE   = 4'h_1, TAP_SEL_DR = 4'h_3,
      TAP_CAP_DR = 4'h_2, TAP_SH_DR  = 4'h_6, TAP_EX1_DR = 4'h_7,
      TAP_PA_DR  = 4'h_5, TAP_EX2_DR = 4'h_4, TAP_UPD_DR = 4'h_C,
      TAP_SEL_IR = 4'h_D, TAP_CAP_IR = 4'h_F, TAP_SH_IR  = 4'h_E,
      TAP_EX1_IR = 4'h_A, TAP_PA_IR  = 4'h_B, TAP_EX2_IR = 4'h_9,
      TAP_UPD_IR = 4'h_8
   } fsl_tap_t;

   // Whole state of the block.
   typedef struct packed {
      fsl_tap_t    tap;
      logic [3:0]  ir;
      logic [31:0] sh;
      logic [6:0]  div_dr;
      logic        armed;
      logic        tck_q;
      logic        tdo;
      logic        tdo_oe;
      logic        ready;
      logic        secured;
      logic        ext_boot;
      logic        key_open;
      logic        erasing;
      logic        erase_done;
      logic [6:0]  div_reg;
      logic [6:0]  div_out;
      logic [31:0] prdata;
   } fsl_state_t;
endpackage

// ===== design/fsl_top.sv
// Flash security interlocks, test port and lockout recovery controller.
//
// Contract
// - Secured part blocks all external program-space accesses.
// - Secured part ignores the external boot strap sampled at reset.
// - Secured part boots internally from boot flash at 0x02_0000.
// - Debug memory-read disable follows the stored security bytes at reset.
// - Security comes from flash bytes, so it returns after every reset.
// - Only the two security bytes decide secured or open.
// - Test port always offers boundary sample and identification read.
// - Recovery erases all flash, clearing the security bytes.
// - Recovery instruction selects its own 7-bit divider data register.
// - During recovery the test divider overrides the flash divider register.
// - Host sets prescale above 12.8 MHz input; flash divides by ratio+1.
// - Erase starts on entering Run-Test/Idle; host stays until done.
// - Backdoor key opening of debug reads works only with the key permit bit set.
module fsl_top (
   // APB slave.
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Flash configuration field contents.
   input  wire logic [7:0]  sec_byte_lo,
   input  wire logic [7:0]  sec_byte_hi,
   input  wire logic        backdoor_key_permit,
   input  wire logic [31:0] backdoor_key,
   // Boot strap pin.
   input  wire logic        external_boot_strap,
   // Test access port pins.
   input  wire logic        jtag_tck,
   input  wire logic        jtag_tms,
   input  wire logic        jtag_tdi,
   input  wire logic        jtag_trst_n,
   output logic             jtag_tdo,
   output logic             jtag_tdo_oe,
   // Flash controller side.
   output logic             flash_erase_all,
   input  wire logic        flash_erase_done,
   output logic             prescale_by_eight,
   output logic [5:0]       flash_div_ratio,
   // Core and chip configuration unit.
   output logic             core_debug_port_read_dis,
   output logic             ext_pspace_block,
   output logic             boot_external,
   output logic [20:0]      boot_vector
);
`include "fsl_consts.svh"

   fsl_pkg::fsl_state_t cur;
   fsl_pkg::fsl_state_t next_cur;

   logic tck_rise;
   logic tck_fall;
   logic wr_en;
   logic rd_setup;
   logic addr_ok;
   logic sec_now;

   ////////////////////////////////////////////////////////////////////////
   // Test controller next state on the test clock edge.
   function automatic fsl_pkg::fsl_tap_t tap_next(
      input fsl_pkg::fsl_tap_t s,
      input logic              tms
   );
      fsl_pkg::fsl_tap_t n;
      n = s;
      unique case (s)
         fsl_pkg::TAP_RESET:
            n = tms ? fsl_pkg::TAP_RESET : fsl_pkg::TAP_IDLE;
         fsl_pkg::TAP_IDLE:
            n = tms ? fsl_pkg::TAP_SEL_DR : fsl_pkg::TAP_IDLE;
         fsl_pkg::TAP_SEL_DR:
            n = tms ? fsl_pkg::TAP_SEL_IR : fsl_pkg::TAP_CAP_DR;
         fsl_pkg::TAP_CAP_DR:
            n = tms ? fsl_pkg::TAP_EX1_DR : fsl_pkg::TAP_SH_DR;
         fsl_pkg::TAP_SH_DR:
            n = tms ? fsl_pkg::TAP_EX1_DR : fsl_pkg::TAP_SH_DR;
         fsl_pkg::TAP_EX1_DR:
            n = tms ? fsl_pkg::TAP_UPD_DR : fsl_pkg::TAP_PA_DR;
         fsl_pkg::TAP_PA_DR:
            n = tms ? fsl_pkg::TAP_EX2_DR : fsl_pkg::TAP_PA_DR;
         fsl_pkg::TAP_EX2_DR:
            n = tms ? fsl_pkg::TAP_UPD_DR : fsl_pkg::TAP_SH_DR;
         fsl_pkg::TAP_UPD_DR:
            n = tms ? fsl_pkg::TAP_SEL_DR : fsl_pkg::TAP_IDLE;
         fsl_pkg::TAP_SEL_IR:
            n = tms ? fsl_pkg::TAP_RESET : fsl_pkg::TAP_CAP_IR;
         fsl_pkg::TAP_CAP_IR:
            n = tms ? fsl_pkg::TAP_EX1_IR : fsl_pkg::TAP_SH_IR;
         fsl_pkg::TAP_SH_IR:
            n = tms ? fsl_pkg::TAP_EX1_IR : fsl_pkg::TAP_SH_IR;
         fsl_pkg::TAP_EX1_IR:
            n = tms ? fsl_pkg::TAP_UPD_IR : fsl_pkg::TAP_PA_IR;
         fsl_pkg::TAP_PA_IR:
            n = tms ? fsl_pkg::TAP_EX2_IR : fsl_pkg::TAP_PA_IR;
         fsl_pkg::TAP_EX2_IR:
            n = tms ? fsl_pkg::TAP_UPD_IR : fsl_pkg::TAP_SH_IR;
         fsl_pkg::TAP_UPD_IR:
            n = tms ? fsl_pkg::TAP_SEL_DR : fsl_pkg::TAP_IDLE;
      endcase
      return n;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Edge detection of the test clock and bus decode.
   // The test pins are sampled on pclk, so the test clock must run below
   // half the core clock; a faster test clock would lose edges.
   assign tck_rise = jtag_tck & ~cur.tck_q;
   assign tck_fall = ~jtag_tck & cur.tck_q;
   assign addr_ok  = (paddr == `FSL_OFS_DIVIDER) ||
                     (paddr == `FSL_OFS_STATUS) ||
                     (paddr == `FSL_OFS_KEY);
   assign wr_en    = psel & penable & pwrite & addr_ok;
   assign rd_setup = psel & ~penable & ~pwrite;
   // Only the two security bytes are compared.
   assign sec_now  = ({sec_byte_hi, sec_byte_lo} != `FSL_UNSECURE_CODE);

   ////////////////////////////////////////////////////////////////////////
   // Next state of the whole block.
   always_comb begin
      next_cur       = cur;
      next_cur.tck_q = jtag_tck;

      // Security bytes and strap are caught once, just after reset.
      // A later change of the bytes, as after the recovery erase, only
      // takes effect at the next chip reset.
      if (!cur.ready) begin
         next_cur.ready    = 1'b1;
         next_cur.secured  = sec_now;
         next_cur.ext_boot = external_boot_strap;
      end

      // Divider register written by software.
      if (wr_en && paddr == `FSL_OFS_DIVIDER) begin
         next_cur.div_reg = pwdata[6:0];
      end

      // Backdoor key opens debug access only with the permit bit.
      if (wr_en && paddr == `FSL_OFS_KEY && backdoor_key_permit &&
          pwdata == backdoor_key) begin
         next_cur.key_open = 1'b1;
      end

      // Read data is prepared in the setup phase, so that the access phase
      // ends after one cycle with pready tied high.
      if (rd_setup) begin
         next_cur.prdata = 32'h_0000_0000;
         if (paddr == `FSL_OFS_DIVIDER) begin
            next_cur.prdata[6:0] = cur.div_reg;
         end else if (paddr == `FSL_OFS_STATUS) begin
            next_cur.prdata[`FSL_ST_SECURED]    = cur.secured;
            next_cur.prdata[`FSL_ST_EXT_BOOT]   = cur.ext_boot;
            next_cur.prdata[`FSL_ST_ERASING]    = cur.erasing;
            next_cur.prdata[`FSL_ST_ERASE_DONE] = cur.erase_done;
            next_cur.prdata[`FSL_ST_KEY_OPEN]   = cur.key_open;
            next_cur.prdata[`FSL_ST_RECOV_SEL]  =
               (cur.ir == `FSL_IR_RECOVERY);
         end
      end

      // Test controller steps on each rising test clock edge.
      // Test reset is taken on pclk and leaves a running erase alone.
      if (!jtag_trst_n) begin
         next_cur.tap   = fsl_pkg::TAP_RESET;
         next_cur.ir    = `FSL_IR_IDCODE;
         next_cur.armed = 1'b0;
      end else if (tck_rise) begin
         next_cur.tap = tap_next(cur.tap, jtag_tms);
         unique case (cur.tap)
            fsl_pkg::TAP_RESET: begin
               next_cur.ir    = `FSL_IR_IDCODE;
               next_cur.armed = 1'b0;
            end
            fsl_pkg::TAP_CAP_IR: begin
               next_cur.sh[3:0] = `FSL_IR_CAPTURE;
            end
            fsl_pkg::TAP_SH_IR: begin
               next_cur.sh[3:0] = {jtag_tdi, cur.sh[3:1]};
            end
            fsl_pkg::TAP_UPD_IR: begin
               next_cur.ir    = cur.sh[3:0];
               next_cur.armed = 1'b0;
            end
            fsl_pkg::TAP_CAP_DR: begin
               next_cur.sh = 32'h_0000_0000;
               if (cur.ir == `FSL_IR_IDCODE) begin
                  next_cur.sh = `FSL_IDCODE;
               end else if (cur.ir == `FSL_IR_SAMPLE) begin
                  next_cur.sh[1:0] = {flash_erase_done,
                                      external_boot_strap};
               end else if (cur.ir == `FSL_IR_RECOVERY) begin
                  next_cur.sh[6:0] = cur.div_dr;
               end
            end
            fsl_pkg::TAP_SH_DR: begin
               if (cur.ir == `FSL_IR_IDCODE) begin
                  next_cur.sh = {jtag_tdi, cur.sh[31:1]};
               end else if (cur.ir == `FSL_IR_SAMPLE) begin
                  next_cur.sh[1:0] = {jtag_tdi, cur.sh[1]};
               end else if (cur.ir == `FSL_IR_RECOVERY) begin
                  next_cur.sh[6:0] = {jtag_tdi, cur.sh[6:1]};
               end else begin
                  // Unknown codes shift through a one-bit bypass stage.
                  next_cur.sh[0] = jtag_tdi;
               end
            end
            fsl_pkg::TAP_UPD_DR: begin
               if (cur.ir == `FSL_IR_RECOVERY) begin
                  next_cur.div_dr = cur.sh[6:0];
                  next_cur.armed  = 1'b1;
               end
            end
            default: begin
            end
         endcase

         // Erase starts on entry to Run-Test/Idle after the update.
         // The arm flag is taken from next_cur, so that the usual path from
         // Update-DR straight into Run-Test/Idle starts the erase on the
         // very test clock edge that loads the divider; the registered flag
         // would be seen one edge late, when no entry is left to detect.
         if (next_cur.armed && cur.ir == `FSL_IR_RECOVERY &&
             cur.tap != fsl_pkg::TAP_IDLE &&
             tap_next(cur.tap, jtag_tms) == fsl_pkg::TAP_IDLE) begin
            next_cur.erasing = 1'b1;
            next_cur.armed   = 1'b0;
         end
      end

      // Erase runs until the flash reports completion.
      // A done report outside an erase is ignored; the done flag then stays
      // set until the next chip reset, so software can see that recovery ran.
      if (cur.erasing && flash_erase_done) begin
         next_cur.erasing    = 1'b0;
         next_cur.erase_done = 1'b1;
      end

      // Test data out changes on the falling test clock edge.
      // Changing on the fall gives the host half a test clock of set-up
      // before it samples at the next rise.
      if (tck_fall) begin
         next_cur.tdo    = cur.sh[0];
         next_cur.tdo_oe = (cur.tap == fsl_pkg::TAP_SH_DR) ||
                           (cur.tap == fsl_pkg::TAP_SH_IR);
      end

      // Recovery divider overrides the software divider.
      // Armed counts as well, so the timer already runs on the host's value.
      next_cur.div_out = (cur.erasing || cur.armed) ? cur.div_dr
                                                    : cur.div_reg;
   end

   ////////////////////////////////////////////////////////////////////////
   // State register.
   // Reset leaves the part secured with debug reads shut, so nothing leaks
   // before the security bytes have been looked at.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur            <= '0;
         cur.tap        <= fsl_pkg::TAP_RESET;
         cur.ir         <= `FSL_IR_IDCODE;
         cur.secured    <= 1'b1;
         cur.div_reg    <= `FSL_DIV_RESET;
         cur.div_out    <= `FSL_DIV_RESET;
      end else begin
         cur <= next_cur;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs.
   assign pready      = 1'b1;
   assign pslverr     = psel & penable & ~addr_ok;
   assign prdata      = cur.prdata;
   assign jtag_tdo    = cur.tdo;
   assign jtag_tdo_oe = cur.tdo_oe;
   assign flash_erase_all   = cur.erasing;
   // Top bit is the prescale select, low six bits the ratio.
   assign prescale_by_eight = cur.div_out[`FSL_DIV_PRESCALE_BIT];
   assign flash_div_ratio   = cur.div_out[5:0];
   // Debug reads blocked when secured without an accepted key, before capture and while erasing.
   assign core_debug_port_read_dis = ~cur.ready | cur.erasing |
                                     (cur.secured & ~cur.key_open);
   assign ext_pspace_block = cur.secured;
   assign boot_external    = cur.ready & cur.ext_boot &
                             ~cur.secured;
   // External boot fetches from the bottom of external program space.
   assign boot_vector      = boot_external ? `FSL_EXT_BOOT_ADDR
                                           : `FSL_BOOT_FLASH_ADDR;
endmodule

// ===== test/fsl_top_properties.sv
// Concurrent checks on the ports of the flash security block.
module fsl_chk (
   // Clock, reset and register bus.
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [11:0] paddr,
   // Security bytes and test clock.
   input wire logic [7:0]  sec_byte_lo,
   input wire logic [7:0]  sec_byte_hi,
   input wire logic        backdoor_key_permit,
   input wire logic        jtag_tck,
   // Erase and interlock outputs.
   input wire logic        flash_erase_all,
   input wire logic        flash_erase_done,
   input wire logic        core_debug_port_read_dis,
   input wire logic        ext_pspace_block,
   input wire logic        boot_external,
   input wire logic [20:0] boot_vector
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] age;
   logic       sec;

   // Outputs only follow the bytes from the first edge after release.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         age <= 2'h_0;
      end else if (age != 2'h_3) begin
         age <= age + 2'h_1;
      end
   end
   assign sec = {sec_byte_hi, sec_byte_lo} != 16'h_E70A;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_pspace; age[1] |-> ext_pspace_block == sec; endproperty
   a_pspace: assert property (p_pspace) else $error("pspace block");
   property p_strap; age[1] && sec |-> !boot_external; endproperty
   a_strap: assert property (p_strap) else $error("strap honoured");
   property p_vector; age[1] && sec |-> boot_vector == 21'h02_0000; endproperty
   a_vector: assert property (p_vector) else $error("boot vector");
   property p_dbg_open;
      age[1] && !sec && !flash_erase_all |-> !core_debug_port_read_dis;
   endproperty
   a_dbg_open: assert property (p_dbg_open) else $error("debug shut");
   property p_dbg_shut;
      age[1] && sec && !backdoor_key_permit |-> core_debug_port_read_dis;
   endproperty
   a_dbg_shut: assert property (p_dbg_shut) else $error("debug open");
   property p_rst;
      disable iff (1'b0) !presetn |-> core_debug_port_read_dis &&
         ext_pspace_block && !boot_external;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   property p_go;
      $rose(flash_erase_all) |-> $past(jtag_tck) && !$past(jtag_tck, 2);
   endproperty
   a_go: assert property (p_go) else $error("erase start");
   property p_hold; flash_erase_all && !flash_erase_done &&
      !$past(flash_erase_done) |=> flash_erase_all; endproperty
   a_hold: assert property (p_hold) else $error("erase dropped");
   property p_end; flash_erase_all && flash_erase_done |-> ##[1:2]
      !flash_erase_all; endproperty
   a_end: assert property (p_end) else $error("erase stuck");
   property p_apb; psel && penable |-> pready && (pslverr ==
      (paddr > 12'h_008 || paddr[1:0] != 2'h_0)); endproperty
   a_apb: assert property (p_apb) else $error("bus answer");

   c_erase: cover property ($rose(flash_erase_all));
   c_err: cover property (psel && penable && pslverr);
   c_key: cover property (sec && !core_debug_port_read_dis);
endmodule

// ===== test/fsl_jtag_host.sv
// Behavioural test-port host that drives the block's test pins.
module fsl_jtag_host (
   // Core clock and returned data.
   input  wire logic pclk,
   input  wire logic jtag_tdo,
   // Driven test pins.
   output logic      jtag_tck,
   output logic      jtag_tms,
   output logic      jtag_tdi,
   output logic      jtag_trst_n
);
   timeunit 1ns;
   timeprecision 1ns;

   // Test clock rests low outside frames; test reset starts asserted.
   initial begin
      jtag_tck = 1'b0;
      jtag_tms = 1'b1;
      jtag_tdi = 1'b0;
      jtag_trst_n = 1'b0;
   end

   // One test clock of nine core cycles; data out is taken at the rise.
   task automatic tick(input logic ms, input logic di, output logic q);
      @(posedge pclk);
      jtag_tms <= ms;
      jtag_tdi <= di;
      repeat (4) @(posedge pclk);
      q = jtag_tdo;
      jtag_tck <= 1'b1;
      repeat (4) @(posedge pclk);
      jtag_tck <= 1'b0;
   endtask

   // Scans one register from idle, updates it and returns to idle.
   task automatic scan(input logic ir, input logic [31:0] d, input int n,
                       output logic [31:0] q);
      logic b;
      q = '0;
      tick(1'b1, ~jtag_tdi, b);
      if (ir) tick(1'b1, ~jtag_tdi, b);
      tick(1'b0, ~jtag_tdi, b);
      tick(1'b0, ~jtag_tdi, b);
      for (int i = 0; i < n; i++) tick(i == n - 1, d[i], q[i]);
      tick(1'b1, ~jtag_tdi, b);
      tick(1'b0, ~jtag_tdi, b);
   endtask

   // Test reset pulse, then a step into idle.
   task automatic trst();
      logic b;
      @(posedge pclk);
      jtag_trst_n <= 1'b0;
      repeat (4) @(posedge pclk);
      jtag_trst_n <= 1'b1;
      tick(1'b0, ~jtag_tdi, b);
   endtask
endmodule

// ===== test/testbench.sv
// Self-checking bench of the flash security block.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, q, d, backdoor_key;
   logic [7:0] sec_byte_lo, sec_byte_hi;
   logic backdoor_key_permit, external_boot_strap, jtag_tck, jtag_tms;
   logic jtag_tdi, jtag_trst_n, jtag_tdo, jtag_tdo_oe, flash_erase_all;
   logic flash_erase_done, prescale_by_eight, core_debug_port_read_dis;
   logic ext_pspace_block, boot_external;
   logic [5:0] flash_div_ratio;
   logic [6:0] dv;
   logic [20:0] boot_vector;
   int bad_count, total_checks, cyc;

   fsl_top i_dut (.*);
   fsl_jtag_host i_host (.*);

   // Core clock and hang guard.
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         final_report();
      end
   end

   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, e, input string m);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask

   // One bus transfer: setup, then access until ready is seen.
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] r,
                      output logic e);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask

   // Chip reset with given flash bytes, then the boot interlocks.
   task automatic boot(input logic [15:0] c, input logic st, pm);
      logic s, x;
      @(posedge pclk);
      presetn <= 1'b0;
      {sec_byte_hi, sec_byte_lo} <= c;
      {external_boot_strap, backdoor_key_permit} <= {st, pm};
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      s = c != 16'h_E70A;
      x = !s && st;
      chk(ext_pspace_block, s, "pspace");
      chk(boot_external, x, "boot mode");
      chk(boot_vector, x ? 32'h_0 : 32'h_0002_0000, "vector");
      chk(core_debug_port_read_dis, s, "debug");
      apb(1'b0, 12'h_004, 32'h_0, rd, err);
      chk(rd[0], s, "status");
      chk(rd[1], st, "strap latched");
   endtask

   // Divider for a 150 to 200 kHz timer from the core clock in MHz.
   function automatic logic [6:0] divcalc(input int mhz);
      int f, n;
      logic pre;
      f = mhz * 500;
      pre = f > 12800;
      if (pre) f = f / 8;
      n = (f + 199) / 200 - 1;
      return {pre, n[5:0]};
   endfunction

   initial begin
      // Reset stays released until the first boot lowers it at an edge.
      presetn = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {sec_byte_lo, sec_byte_hi, backdoor_key, flash_erase_done} = '0;
      {backdoor_key_permit, external_boot_strap} = '0;
      {bad_count, total_checks, cyc} = '0;
      d = $urandom(10465);
      for (int i = 0; i < 8; i++) begin
         boot(i % 3 == 0 ? 16'h_E70A : i == 1 ? 16'h_0AE7 : $urandom,
              i[1], 1'b0);
      end
      // Divider register, unmapped place and a refused key.
      d = $urandom;
      apb(1'b1, 12'h_000, d, rd, err);
      apb(1'b0, 12'h_000, 32'h_0, rd, err);
      chk(rd, {25'h_0, d[6:0]}, "divider");
      chk({prescale_by_eight, flash_div_ratio}, d[6:0], "div out");
      apb(1'b0, 12'h_00C, 32'h_0, rd, err);
      chk(err, 1'b1, "unmapped error");
      chk(rd, 32'h_0, "unmapped data");
      backdoor_key = $urandom;
      apb(1'b1, 12'h_008, backdoor_key, rd, err);
      chk(core_debug_port_read_dis, 1'b1, "key no permit");
      boot(16'h_1234, 1'b0, 1'b1);
      apb(1'b1, 12'h_008, ~backdoor_key, rd, err);
      chk(core_debug_port_read_dis, 1'b1, "wrong key");
      apb(1'b1, 12'h_008, backdoor_key, rd, err);
      repeat (2) @(posedge pclk);
      chk({core_debug_port_read_dis, ext_pspace_block}, 2'b01, "key");
      // Test port on a secured part, then lockout recovery.
      boot(16'h_0000, 1'b1, 1'b1);
      apb(1'b1, 12'h_008, backdoor_key, rd, err);
      i_host.trst();
      chk(core_debug_port_read_dis, 1'b0, "key before erase");
      i_host.scan(1'b0, 32'h_0, 32, q);
      chk(q, 32'h_1234_5001, "ident");
      chk(jtag_tdo_oe, 1'b0, "tdo idle");
      i_host.scan(1'b1, 32'h_1, 4, q);
      chk(q[3:0], 4'h_1, "ir capture");
      i_host.scan(1'b0, 32'h_0, 2, q);
      chk(q[1:0], 2'b01, "sample");
      i_host.scan(1'b1, 32'h_F, 4, q);
      i_host.scan(1'b0, 32'h_1, 2, q);
      chk(q[1:0], 2'b10, "bypass");
      dv = divcalc(4 + $urandom % 117);
      i_host.scan(1'b1, 32'h_8, 4, q);
      i_host.scan(1'b0, {25'h_0, dv}, 7, q);
      chk(flash_erase_all, 1'b1, "erase start");
      chk({prescale_by_eight, flash_div_ratio}, dv, "override");
      apb(1'b0, 12'h_004, 32'h_0, rd, err);
      chk({rd[5], rd[3:2]}, 3'b101, "erasing");
      repeat (40) @(posedge pclk);
      chk({flash_erase_all, core_debug_port_read_dis}, 2'b11, "hold");
      flash_erase_done <= 1'b1;
      @(posedge pclk);
      flash_erase_done <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(flash_erase_all, 1'b0, "erase end");
      apb(1'b0, 12'h_004, 32'h_0, rd, err);
      chk({rd[3], rd[0]}, 2'b11, "done, relatch later");
      i_host.trst();
      boot(16'h_E70A, 1'b0, 1'b0);
      final_report();
   end
endmodule

bind fsl_top fsl_chk i_chk (.*);
